// ==== core/epob_eprom_ctrl.sv ====
module epob_eprom_ctrl
  import epob_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [15:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  input  wire logic [3:0]              pstrb_in,
  output logic [31:0]                  prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // CPU array port
  input  wire logic                    arr_wr_in,
  input  wire logic                    arr_rd_in,
  input  wire logic [EPOB_ARR_AW-1:0]  arr_addr_in,
  input  wire logic [7:0]              arr_wdata_in,
  output logic [7:0]                   arr_rdata_out,
  output logic                         arr_fetch_ok_out,
  // Core state
  input  wire logic                    stop_in,
  input  wire logic                    wait_in,
  input  wire logic [7:0]              port_b_dir_in,
  input  wire logic [7:0]              port_c_dir_in,
  // Mode pins
  input  wire logic                    capture_input_pin_in,
  input  wire logic                    mode_select0_in,
  input  wire logic                    mode_select1_in,
  input  wire logic                    mode_select2_in,
  // Outputs to the system
  output logic                         reset_pin_low_out,
  output logic                         boot_vector_sel_out,
  output logic [2:0]                   boot_mode_out,
  output logic                         watchdog_run_out,
  output logic [7:0]                   second_port_pulldown_out,
  output logic [7:0]                   third_port_pulldown_out,
  output logic                         external_clock_option_out,
  output logic                         program_busy_out
);

  epob_mode_t                mode;
  logic                      boot_mode;
  logic                      first_cycle;
  logic [7:0]                opt_r = EPOB_OPT_ERASED;
  logic                      mirror_r;
  logic                      latch_r;
  logic                      pgm_r;
  logic                      external_clock_option_r;
  logic [EPOB_ARR_AW-3:0]    lat_base_r;
  logic [7:0]                lat_data_r [EPOB_LATCH_BYTES];
  logic [3:0]                lat_valid_r;
  logic                      prog_done_r;
  logic [11:0]               porl_cnt_r;
  logic                      porl_run_r;
  logic [11:0]               porl_age_r;
  logic [7:0]                arr_mem [EPOB_ARR_DEPTH] = '{default: 8'h00}; // Erased cells read zero
  logic [7:0]                arr_rdata_r;
  logic [31:0]               prdata_r;
  logic                      setup;
  logic                      access;
  logic                      hit_ctrl;
  logic                      hit_opts;
  logic                      wr_ctrl;
  logic                      wr_opts;
  logic                      latch_nxt;
  logic                      pgm_nxt;
  logic                      capture_wr;
  logic                      prog_fire;

  epob_mode_sample u_mode (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .capture_input_pin_in (capture_input_pin_in),
    .mode_select0_in      (mode_select0_in),
    .mode_select1_in      (mode_select1_in),
    .mode_select2_in      (mode_select2_in),
    .mode_out             (mode),
    .boot_mode_out        (boot_mode),
    .first_cycle_out      (first_cycle)
  );

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign setup       = psel_in && !penable_in;
  assign access      = psel_in && penable_in;
  assign hit_ctrl    = (paddr_in == EPOB_ADDR_CTRL);
  assign hit_opts    = (paddr_in == EPOB_ADDR_OPTS);
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !hit_ctrl && !hit_opts;
  assign wr_ctrl     = access && pwrite_in && hit_ctrl && pstrb_in[0];
  assign wr_opts     = access && pwrite_in && hit_opts && pstrb_in[0];

  // Read data is built in the setup cycle so it comes from a flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      if (hit_ctrl) begin
        prdata_r <= {24'h00_0000, 1'b0, mirror_r, latch_r, pgm_r, external_clock_option_r, 3'h0};
      end else if (hit_opts) begin
        prdata_r <= {24'h00_0000, 1'b0, opt_r[6:0] & EPOB_OPT_WMASK[6:0]};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end
  assign prdata_out = prdata_r;

  // Options live in EPROM: no reset term at all, only boot-mode writes
  always_ff @(posedge clk_in) begin
    if (wr_opts && boot_mode) begin
      opt_r <= pwdata_in[7:0] & EPOB_OPT_WMASK;
    end
  end

  // Mirror is caught by a clocked load just after release, never in reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mirror_r <= 1'b0;
    end else if (first_cycle) begin
      mirror_r <= opt_r[EPOB_OPT_PROTECT];
    end
  end

  // Next control values; program enable only sets, and clears only when the latch clears
  always_comb begin
    latch_nxt = latch_r;
    pgm_nxt   = pgm_r;
    if (wr_ctrl) begin
      latch_nxt = pwdata_in[EPOB_CTL_LATCH];
      if (pwdata_in[EPOB_CTL_PGM] && latch_r && (lat_valid_r != 4'h0)) begin
        pgm_nxt = 1'b1;
      end
    end
    if (stop_in) begin
      latch_nxt = 1'b0;
    end
    if (!latch_nxt) begin
      pgm_nxt = 1'b0;
    end
  end

  // Control register flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r <= 1'b0;
      pgm_r   <= 1'b0;
      external_clock_option_r  <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      pgm_r   <= pgm_nxt;
      if (wr_ctrl) begin
        external_clock_option_r <= pwdata_in[EPOB_CTL_EXTERNAL_CLOCK_OPTION];
      end
    end
  end
  assign external_clock_option_out = external_clock_option_r;

  // Array writes become captures while latching and not yet programming
  assign capture_wr = arr_wr_in && latch_r && !pgm_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_base_r  <= '0;
      lat_valid_r <= 4'h0;
    end else if (!latch_r) begin
      lat_valid_r <= 4'h0;
    end else if (capture_wr) begin
      lat_base_r                    <= arr_addr_in[EPOB_ARR_AW-1:2];
      lat_valid_r[arr_addr_in[1:0]] <= 1'b1;
    end
  end

  // Data bytes need no reset; the valid mask guards them
  always_ff @(posedge clk_in) begin
    if (capture_wr) begin
      lat_data_r[arr_addr_in[1:0]] <= arr_wdata_in;
    end
  end

  // One programming pass per program enable; protect suppresses it
  assign prog_fire = pgm_r && !prog_done_r && !opt_r[EPOB_OPT_PROTECT];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_done_r <= 1'b0;
    end else if (!pgm_r) begin
      prog_done_r <= 1'b0;
    end else begin
      prog_done_r <= 1'b1;
    end
  end
  assign program_busy_out = pgm_r;

  // Cells only gain ones, as in a real EPROM; all latched bytes in one pass
  always_ff @(posedge clk_in) begin
    if (prog_fire) begin
      for (int i = 0; i < EPOB_LATCH_BYTES; i++) begin
        if (lat_valid_r[i]) begin
          arr_mem[{lat_base_r, i[1:0]}] <= arr_mem[{lat_base_r, i[1:0]}] | lat_data_r[i];
        end
      end
    end
  end

  // Reads see zero and fetch is refused while latching; code must run in RAM
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arr_rdata_r <= 8'h00;
    end else if (arr_rd_in) begin
      arr_rdata_r <= latch_r ? 8'h00 : arr_mem[arr_addr_in];
    end
  end
  assign arr_rdata_out    = arr_rdata_r;
  assign arr_fetch_ok_out = !latch_r;

  // Reset pin held low after power-on, length from the reset time option
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      porl_cnt_r <= 12'h000;
      porl_run_r <= 1'b1;
    end else if (porl_run_r) begin
      if (porl_cnt_r == (opt_r[EPOB_OPT_RESET_TIME_OPTION] ? EPOB_PORL_SHORT : EPOB_PORL_LONG) - 12'h001) begin
        porl_run_r <= 1'b0;
      end else begin
        porl_cnt_r <= porl_cnt_r + 12'h001;
      end
    end
  end
  assign reset_pin_low_out = porl_run_r;

  // Cycles since release; a yardstick kept apart from the pin counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      porl_age_r <= 12'h000;
    end else if (porl_age_r != 12'hFFF) begin
      porl_age_r <= porl_age_r + 12'h001;
    end
  end

  // Boot mode selects the bootstrap reset vector
  assign boot_vector_sel_out = boot_mode;
  assign boot_mode_out       = mode;

  // Watchdog gating from the options
  assign watchdog_run_out = opt_r[EPOB_OPT_WATCHDOG_AFTER_RESET_OPTION] && !boot_mode
                            && (!wait_in || opt_r[EPOB_OPT_WATCHDOG_IN_WAIT_OPTION]);

  // Pull-downs act only on pins whose direction bit marks an input
  assign second_port_pulldown_out = {8{opt_r[EPOB_OPT_SECOND_PORT_PULLDOWN]}} & ~port_b_dir_in;
  assign third_port_pulldown_out  = {8{opt_r[EPOB_OPT_THIRD_PORT_PULLDOWN]}} & ~port_c_dir_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ctrl_bit7_zero: assert property (
    $past(setup && !pwrite_in && hit_ctrl) |-> !prdata_out[7])
    else $error("control bit 7 read nonzero");

  a_mirror_load: assert property (
    first_cycle |=> (mirror_r == $past(opt_r[EPOB_OPT_PROTECT])))
    else $error("mirror not loaded from protect bit");

  a_capture_only: assert property (
    (lat_valid_r != $past(lat_valid_r)) && (lat_valid_r != 4'h0) |-> $past(capture_wr))
    else $error("byte latched without capture write");

  a_stop_clears: assert property (
    stop_in |=> !latch_r && !pgm_r)
    else $error("stop did not clear latch");

  a_pgm_gate: assert property (
    $rose(pgm_r) |-> $past(latch_r) && ($past(lat_valid_r) != 4'h0))
    else $error("program enable set without latched byte");

  a_pgm_sticky: assert property (
    pgm_r && latch_nxt |=> pgm_r)
    else $error("program enable cleared while latch held");

  a_opts_locked: assert property (
    !boot_mode && !first_cycle |=> $stable(opt_r))
    else $error("options changed outside boot mode");

  a_protect_block: assert property (
    prog_fire |-> !opt_r[EPOB_OPT_PROTECT])
    else $error("programming while protected");

  a_fetch_block: assert property (
    latch_r |-> !arr_fetch_ok_out)
    else $error("array available while latched");

  a_latched_read: assert property (
    latch_r && arr_rd_in |=> arr_rdata_out == 8'h00)
    else $error("array data visible while latched");

  a_latch_drop: assert property (
    !latch_r |=> lat_valid_r == 4'h0)
    else $error("latched bytes kept after latch cleared");

  a_short_porl: assert property (
    $fell(porl_run_r) && opt_r[EPOB_OPT_RESET_TIME_OPTION] |-> porl_age_r == EPOB_PORL_SHORT)
    else $error("short reset time wrong");

  a_long_porl: assert property (
    $fell(porl_run_r) && !opt_r[EPOB_OPT_RESET_TIME_OPTION] |-> porl_age_r == EPOB_PORL_LONG)
    else $error("long reset time wrong");

  a_pulldown_dir: assert property (
    ((second_port_pulldown_out & port_b_dir_in) == 8'h00)
    && ((third_port_pulldown_out & port_c_dir_in) == 8'h00))
    else $error("pull-down on an output pin");

  c_capture:   cover property (capture_wr ##[1:20] $rose(pgm_r));
  c_program:   cover property (prog_fire);
  c_boot_opts: cover property (wr_opts && boot_mode);
  c_porl_end:  cover property ($fell(porl_run_r));
  c_boot_entry: cover property ($rose(boot_mode));

endmodule : epob_eprom_ctrl

// ==== core/epob_mode_sample.sv ====
module epob_mode_sample
  import epob_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Mode pins from the programming board
  input  wire logic       capture_input_pin_in,
  input  wire logic       mode_select0_in,
  input  wire logic       mode_select1_in,
  input  wire logic       mode_select2_in,
  // Sampled mode
  output epob_mode_t      mode_out,
  output logic            boot_mode_out,
  output logic            first_cycle_out
);

  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [1:0] rel_cnt_r;
  epob_mode_t mode_r;

  // Two-stage synchroniser; only the second stage is read below
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {capture_input_pin_in, mode_select2_in, mode_select1_in, mode_select0_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pins seen at the first edge after release reach stage two by the third edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rel_cnt_r <= 2'h0;
      mode_r    <= EPOB_MODE_SINGLE;
    end else if (rel_cnt_r != 2'h3) begin
      rel_cnt_r <= rel_cnt_r + 2'h1;
      if (rel_cnt_r == 2'h2) begin
        mode_r <= epob_decode(pin_sync_r[3], pin_sync_r[0], pin_sync_r[1], pin_sync_r[2]);
      end
    end
  end

  assign mode_out        = mode_r;
  assign boot_mode_out   = (mode_r != EPOB_MODE_SINGLE);
  assign first_cycle_out = (rel_cnt_r == 2'h2);

endmodule : epob_mode_sample

// ==== core/epob_pkg.sv ====
package epob_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] EPOB_IDX_CTRL      = 16'h0007;
  localparam logic [15:0] EPOB_IDX_OPTS      = 16'h1EFE;
  localparam logic [15:0] EPOB_ADDR_CTRL     = 16'h001C;
  localparam logic [15:0] EPOB_ADDR_OPTS     = 16'h7BF8;

  // Control register fields
  localparam int          EPOB_CTL_MIRROR    = 6;
  localparam int          EPOB_CTL_LATCH     = 5;
  localparam int          EPOB_CTL_PGM       = 4;
  localparam int          EPOB_CTL_EXTERNAL_CLOCK_OPTION      = 3;

  // Options register fields
  localparam int          EPOB_OPT_PROTECT   = 6;
  localparam int          EPOB_OPT_RESET_TIME_OPTION      = 4;
  localparam int          EPOB_OPT_WATCHDOG_AFTER_RESET_OPTION      = 3;
  localparam int          EPOB_OPT_WATCHDOG_IN_WAIT_OPTION      = 2;
  localparam int          EPOB_OPT_SECOND_PORT_PULLDOWN      = 1;
  localparam int          EPOB_OPT_THIRD_PORT_PULLDOWN      = 0;
  localparam logic [7:0]  EPOB_OPT_WMASK     = 8'h5F;
  localparam logic [7:0]  EPOB_OPT_ERASED    = 8'h00;

  // Array geometry
  localparam int          EPOB_ARR_AW        = 13;
  localparam int          EPOB_ARR_DEPTH     = 8192;
  localparam int          EPOB_LATCH_BYTES   = 4;

  // Reset pin low time after power-on, in cycles
  localparam logic [11:0] EPOB_PORL_SHORT    = 12'h010;
  localparam logic [11:0] EPOB_PORL_LONG     = 12'hFE0;

  // Boot modes sampled at reset release
  typedef enum logic [2:0] {
    EPOB_MODE_SINGLE,
    EPOB_MODE_ERASE_VERIFY,
    EPOB_MODE_PAR_EPROM,
    EPOB_MODE_SERIAL,
    EPOB_MODE_PAR_RAM
  } epob_mode_t;

  // Decode of the three select pins with capture pin high
  function automatic epob_mode_t epob_decode(input logic cap, input logic s0, input logic s1, input logic s2);
    epob_mode_t m;
    m = EPOB_MODE_SINGLE;
    if (cap) begin
      if (!s0 && s1 && !s2) begin
        m = EPOB_MODE_ERASE_VERIFY;
      end else if (!s1 && !s2) begin
        m = EPOB_MODE_PAR_EPROM;
      end else if (s1 && s2) begin
        m = EPOB_MODE_SERIAL;
      end else if (!s1 && s2) begin
        m = EPOB_MODE_PAR_RAM;
      end
    end
    return m;
  endfunction : epob_decode

endpackage : epob_pkg

// ==== dv/epob_board.sv ====
module epob_board
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Pattern to present: capture, select2, select1, select0
  input  wire logic [3:0] pins_in,
  // Mode pins towards the device
  output logic            capture_input_pin_out,
  output logic            mode_select0_out,
  output logic            mode_select1_out,
  output logic            mode_select2_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] hold_cnt_r;
  logic [3:0] pins_r;

  // Load the pattern while reset is low, hold past release, then wander
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hold_cnt_r <= 3'h0;
      pins_r     <= pins_in;
    end else if (hold_cnt_r != 3'h4) begin
      hold_cnt_r <= hold_cnt_r + 3'h1;
    end else begin
      pins_r <= ~pins_r;  // Wander, so a late sample shows
    end
  end

  assign capture_input_pin_out = pins_r[3];
  assign mode_select2_out      = pins_r[2];
  assign mode_select1_out      = pins_r[1];
  assign mode_select0_out      = pins_r[0];
endmodule : epob_board

// ==== dv/tb_top.sv ====
module tb_top
  import epob_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_n, psel, penable, pwrite, arr_wr, arr_rd, stop_s, wait_s, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb, sel;
  logic [12:0] arr_addr;
  logic [7:0]  arr_wdata, arr_rdata, b_dir, c_dir, b_pd, c_pd;
  logic        pready, pslverr, fetch_ok, rpin_low, vec_sel, wdog, external_clock_option, busy;
  logic        cap_w, s0_w, s1_w, s2_w;
  logic [2:0]  bmode;
  int          errors, checks, cycles;
  logic [3:0]  pin_tab [6] = '{4'h0, 4'hB, 4'hA, 4'h8, 4'hE, 4'hC};
  logic [2:0]  mode_tab [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [7:0]  pat [4] = '{8'hA5, 8'h3C, 8'h0F, 8'h81};

  epob_eprom_ctrl epob_eprom_ctrl_i (
    .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .arr_wr_in(arr_wr), .arr_rd_in(arr_rd), .arr_addr_in(arr_addr),
    .arr_wdata_in(arr_wdata), .arr_rdata_out(arr_rdata), .arr_fetch_ok_out(fetch_ok), .stop_in(stop_s),
    .wait_in(wait_s), .port_b_dir_in(b_dir), .port_c_dir_in(c_dir), .capture_input_pin_in(cap_w),
    .mode_select0_in(s0_w), .mode_select1_in(s1_w), .mode_select2_in(s2_w), .reset_pin_low_out(rpin_low),
    .boot_vector_sel_out(vec_sel), .boot_mode_out(bmode), .watchdog_run_out(wdog),
    .second_port_pulldown_out(b_pd), .third_port_pulldown_out(c_pd), .external_clock_option_out(external_clock_option),
    .program_busy_out(busy));

  epob_board epob_board_i (
    .clk_in(clk), .rst_n_in(rst_n), .pins_in(sel), .capture_input_pin_out(cap_w),
    .mode_select0_out(s0_w), .mode_select1_out(s1_w), .mode_select2_out(s2_w));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cut a hang short; the whole run needs under 5000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask : chk8

  task automatic chk_cnt(input int g, input int x);
    checks++;
    if (g != x) begin
      errors++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, g, x);
    end
  endtask : chk_cnt

  // Reset with a pin pattern; optionally time the reset pin
  task automatic do_reset(input logic [3:0] pins, input int exp_low);
    int n;
    n = 0;
    @(posedge clk);
    sel <= pins;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    if (exp_low > 0) begin
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (rpin_low !== 1'b0 && n < 5000);
      chk_cnt(n, exp_low);
    end else begin
      repeat (4) @(posedge clk);
    end
  endtask : do_reset

  // One APB transfer; read data and error land in d and e
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk8(d[7:0], x);
  endtask : rd

  // One array cycle; a read is compared one edge later
  task automatic arr(input logic wr, input logic [12:0] a, input logic [7:0] wd, input logic [7:0] x);
    @(posedge clk);
    arr_wr <= wr;
    arr_rd <= ~wr;
    arr_addr <= a;
    arr_wdata <= wd;
    @(posedge clk);
    arr_wr <= 1'b0;
    arr_rd <= 1'b0;
    if (!wr) begin
      #1;
      chk8(arr_rdata, x);
    end
  endtask : arr

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    arr_wr = 1'b0;
    arr_rd = 1'b0;
    arr_addr = 13'h0000;
    arr_wdata = 8'h00;
    stop_s = 1'b0;
    wait_s = 1'b0;
    b_dir = 8'hF0;
    c_dir = 8'h0F;
    sel = 4'h0;
    errors = 0;
    checks = 0;
    cycles = 0;
    // Erased options, single chip: long reset, locked options
    do_reset(4'h0, 4064);
    rd(EPOB_ADDR_CTRL, 8'h00);
    apb(1'b1, EPOB_ADDR_OPTS, 8'h5F);
    rd(EPOB_ADDR_OPTS, 8'h00);
    apb(1'b0, 16'h0020, 8'h00);
    chk8({7'h00, e}, 8'h01);
    chk8({wdog, b_pd[6:0]}, 8'h00);
    arr(1'b0, 13'h0104, 8'h00, 8'h00);
    chk8({7'h00, fetch_ok}, 8'h01);
    // Program enable refused without latch, then without a byte
    apb(1'b1, EPOB_ADDR_CTRL, 8'h18);
    rd(EPOB_ADDR_CTRL, 8'h08);
    chk8({7'h00, external_clock_option}, 8'h01);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h20);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h30);
    rd(EPOB_ADDR_CTRL, 8'h20);
    chk8({7'h00, fetch_ok}, 8'h00);
    for (int i = 0; i < 4; i++) arr(1'b1, 13'h0104 + 13'(i), pat[i], 8'h00);
    arr(1'b0, 13'h0104, 8'h00, 8'h00);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h30);
    rd(EPOB_ADDR_CTRL, 8'h30);
    chk8({7'h00, busy}, 8'h01);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h20);
    rd(EPOB_ADDR_CTRL, 8'h30);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h00);
    rd(EPOB_ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) arr(1'b0, 13'h0104 + 13'(i), 8'h00, pat[i]);
    // Latched byte dropped when the latch clears
    apb(1'b1, EPOB_ADDR_CTRL, 8'h20);
    arr(1'b1, 13'h0200, 8'hFF, 8'h00);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h00);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h20);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h30);
    rd(EPOB_ADDR_CTRL, 8'h20);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h00);
    arr(1'b0, 13'h0200, 8'h00, 8'h00);
    // Every mode pattern; pins wander after the hold
    for (int k = 0; k < 6; k++) begin
      do_reset(pin_tab[k], 0);
      repeat (6) @(posedge clk);
      #1;
      chk8({5'h00, bmode}, {5'h00, mode_tab[k]});
      chk8({7'h00, vec_sel}, {7'h00, mode_tab[k] != 3'h0});
    end
    // Boot mode: options writable, bit 7 and bit 5 read zero
    apb(1'b1, EPOB_ADDR_OPTS, 8'h5F);
    rd(EPOB_ADDR_OPTS, 8'h5F);
    chk8(b_pd, 8'h0F);
    chk8(c_pd, 8'hF0);
    chk8({7'h00, wdog}, 8'h00);
    // Options survive reset; mirror follows protect
    do_reset(4'h0, 16);
    rd(EPOB_ADDR_OPTS, 8'h5F);
    rd(EPOB_ADDR_CTRL, 8'h40);
    chk8({7'h00, wdog}, 8'h01);
    wait_s <= 1'b1;
    @(posedge clk);
    #1;
    chk8({7'h00, wdog}, 8'h01);
    wait_s <= 1'b0;
    apb(1'b1, EPOB_ADDR_OPTS, 8'h00);
    rd(EPOB_ADDR_OPTS, 8'h5F);
    // Protected array: latch, byte, program, then STOP
    apb(1'b1, EPOB_ADDR_CTRL, 8'h20);
    rd(EPOB_ADDR_CTRL, 8'h60);
    arr(1'b1, 13'h0300, 8'h77, 8'h00);
    apb(1'b1, EPOB_ADDR_CTRL, 8'h30);
    stop_s <= 1'b1;
    @(posedge clk);
    stop_s <= 1'b0;
    rd(EPOB_ADDR_CTRL, 8'h40);
    arr(1'b0, 13'h0300, 8'h00, 8'h00);
    arr(1'b0, 13'h0104, 8'h00, 8'hA5);
    // Watchdog stops in WAIT once its option is cleared
    do_reset(4'hC, 0);
    apb(1'b1, EPOB_ADDR_OPTS, 8'h5B);
    do_reset(4'h0, 16);
    chk8({7'h00, wdog}, 8'h01);
    wait_s <= 1'b1;
    @(posedge clk);
    #1;
    chk8({7'h00, wdog}, 8'h00);
    wait_s <= 1'b0;
    close_out();
  end
endmodule : tb_top
